// ===== core/rtc_port_pkg.sv
// constants shared by the multiplexed-bus clock host port
package rtc_port_pkg;

    // ****************************************************************
    // clocking
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned OSC_HZ          = 32_768;
    // one oscillator tick every this many system clocks (rounded down)
    localparam int unsigned OSC_TICK_CYCLES = CLK_HZ / OSC_HZ;
    localparam int unsigned DIV_STAGES      = 15;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [6:0] REG_CTRL_A  = 7'h0A;
    localparam logic [6:0] REG_CTRL_B  = 7'h0B;
    localparam logic [6:0] REG_STATUS  = 7'h0C;
    localparam logic [6:0] REG_VALID   = 7'h0D;
    localparam logic [6:0] RAM_FIRST   = 7'h0E;
    localparam int unsigned MEM_WORDS  = 128;
    localparam logic [7:0] RAM_FILL    = 8'hFF;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned A_UIP_BIT  = 7;
    localparam int unsigned B_PIE_BIT  = 6;
    localparam int unsigned B_AIE_BIT  = 5;
    localparam int unsigned B_UIE_BIT  = 4;
    localparam int unsigned B_SQUARE_WAVE_ENABLE_BIT = 3;
    localparam int unsigned C_INTERRUPT_REQUEST_FLAG_BIT = 7;
    localparam int unsigned C_PF_BIT   = 6;
    localparam int unsigned C_AF_BIT   = 5;
    localparam int unsigned C_UF_BIT   = 4;
    localparam int unsigned D_VRT_BIT  = 7;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [6:0] CTRL_A_RESET = 7'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [2:0] FLAGS_RESET  = 3'h0;

endpackage

// ===== core/bit_sync2.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps

module bit_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule

// ===== core/muxed_bus_rtc_host_port.sv
// multiplexed address/data host port of a battery-backed real-time clock
// Overview of operation
// - high bus_type_select picks direction-strobe mode, low picks separate strobes.
// - address byte is captured when addr_strobe falls.
// - write data taken on data_strobe fall, or on write strobe rise.
// - read data driven late in cycle per mode's strobe levels.
// - read ends, bus released, on data_strobe fall or rise per mode.
// - access only with chip select low; address still captured without it.
// - below power-fail threshold, chip select is forced inactive.
// - captured address discarded on next addr_strobe rise.
// - direction-strobe mode: direction high is read, low is write.
// - separate-strobe mode: data_strobe is read enable, direction is write enable.
// - reset low with good supply clears enables, periodic and alarm flags, square-wave enable, irq.
// - no bus access while reset is held low.
// - reset leaves time, calendar and RAM bytes alone.
// - irq pulled low while any flag and its enable are both set.
// - reading status releases irq; reset also clears pending periodic and alarm interrupts.
// - ram_clear_n low in backup fills all 114 RAM bytes with ones.
// - square wave is one of 13 divider taps, gated by enable and supply.
// - status and supply-valid registers ignore writes.
`timescale 1ns/1ps

module muxed_bus_rtc_host_port (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_bus_type_select,
    input  wire logic [7:0] i_shared_addr_data,
    output logic      [7:0] o_shared_addr_data,
    output logic            o_shared_addr_data_oe,
    input  wire logic       i_addr_strobe,
    input  wire logic       i_data_strobe,
    input  wire logic       i_read_write,
    input  wire logic       i_chip_select_n,
    input  wire logic       i_reset_n,
    input  wire logic       i_ram_clear_n,
    input  wire logic       i_power_fail,
    input  wire logic       i_supply_valid,
    input  wire logic       i_update_in_progress,
    input  wire logic       i_periodic_event,
    input  wire logic       i_alarm_event,
    input  wire logic       i_update_event,
    output logic            o_irq_n,
    output logic            o_irq_n_oe,
    output logic            o_square_wave_out,
    output logic      [6:0] o_control_a,
    output logic      [7:0] o_control_b
);
    import rtc_port_pkg::*;

    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    localparam int unsigned SW = 15;

    logic [SW-1:0] pins_sync;
    logic [SW-1:0] pins_prev;

    // all bus pins pass two flops before use
    bit_sync2 #(
        .WIDTH (SW)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async ({i_bus_type_select, i_addr_strobe, i_data_strobe,
                   i_read_write, i_chip_select_n, i_reset_n,
                   i_ram_clear_n, i_shared_addr_data}),
        .o_sync  (pins_sync)
    );

    logic       bus_type;
    logic       as_s;
    logic       ds_s;
    logic       rw_s;
    logic       cs_n_s;
    logic       rst_n_s;
    logic       clr_n_s;
    logic [7:0] ad_s;
    logic       as_p;
    logic       ds_p;
    logic       rw_p;
    logic       cs_n_p;
    logic [7:0] ad_p;

    assign {bus_type, as_s, ds_s, rw_s, cs_n_s, rst_n_s, clr_n_s, ad_s} = pins_sync;
    assign {as_p, ds_p, rw_p, cs_n_p, ad_p} = {pins_prev[13:10], pins_prev[7:0]};

    // previous synchronised levels for edge detection
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pins_prev <= '0;
        end else begin
            pins_prev <= pins_sync;
        end
    end

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic       dev_reset;
    logic       sel_now;
    logic       sel_prev;
    logic       addr_valid;
    logic [6:0] addr;
    logic       as_fall;
    logic       as_rise;
    logic       read_drive;
    logic       write_take;
    logic       read_end;

    // reset pin only acts while supply is good
    assign dev_reset = ~rst_n_s & ~i_power_fail;
    assign as_fall   = as_p & ~as_s;
    assign as_rise   = ~as_p & as_s;

    // power fail and reset pin mask chip select
    assign sel_now  = ~cs_n_s & ~i_power_fail & rst_n_s & addr_valid;
    assign sel_prev = ~cs_n_p & ~i_power_fail & rst_n_s & addr_valid;

    // mode-dependent strobe meaning
    always_comb begin
        if (bus_type) begin
            read_drive = sel_now & ds_s & rw_s;
            write_take = sel_prev & ds_p & ~ds_s & ~rw_p;
            read_end   = sel_prev & ds_p & ~ds_s & rw_p;
        end else begin
            read_drive = sel_now & ~ds_s & rw_s;
            write_take = sel_prev & ~rw_p & rw_s;
            read_end   = sel_prev & ~ds_p & ds_s;
        end
    end

    // bus released as soon as the read strobe ends
    assign o_shared_addr_data_oe = read_drive;

    logic       next_addr_valid;
    logic [6:0] next_addr;

    // address latch: captured on fall, discarded on rise
    always_comb begin
        next_addr_valid = addr_valid;
        next_addr       = addr;
        if (as_fall) begin
            next_addr_valid = 1'b1;
            next_addr       = ad_p[6:0];
        end else if (as_rise) begin
            next_addr_valid = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            addr_valid <= 1'b0;
            addr       <= 7'h00;
        end else begin
            addr_valid <= next_addr_valid;
            addr       <= next_addr;
        end
    end

    // ****************************************************************
    // control and status registers
    // ****************************************************************
    logic [6:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [2:0] flags;
    logic       irq_active;
    logic [6:0] next_ctrl_a;
    logic [7:0] next_ctrl_b;
    logic [2:0] next_flags;
    logic       next_irq_active;
    logic [2:0] enables;
    logic       status_read;

    assign enables     = {ctrl_b[B_PIE_BIT], ctrl_b[B_AIE_BIT], ctrl_b[B_UIE_BIT]};
    assign status_read = read_end & (addr == REG_STATUS);

    // register writes, flag set/clear and reset-pin clears
    always_comb begin
        next_ctrl_a = ctrl_a;
        next_ctrl_b = ctrl_b;
        next_flags  = flags;
        if (write_take && addr == REG_CTRL_A) begin
            next_ctrl_a = ad_p[6:0];
        end
        if (write_take && addr == REG_CTRL_B) begin
            next_ctrl_b = ad_p;
        end
        // status and supply-valid writes fall through unused
        if (status_read) begin
            next_flags = 3'h0;
        end
        // an event in the clearing cycle survives
        next_flags = next_flags | {i_periodic_event, i_alarm_event, i_update_event};
        if (dev_reset) begin
            next_ctrl_b[B_PIE_BIT]  = 1'b0;
            next_ctrl_b[B_AIE_BIT]  = 1'b0;
            next_ctrl_b[B_UIE_BIT]  = 1'b0;
            next_ctrl_b[B_SQUARE_WAVE_ENABLE_BIT] = 1'b0;
            next_flags[2:1]         = 2'b00;
        end
        // request follows any flag paired with its enable
        next_irq_active = |(next_flags & {next_ctrl_b[B_PIE_BIT],
                                          next_ctrl_b[B_AIE_BIT],
                                          next_ctrl_b[B_UIE_BIT]});
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_a     <= CTRL_A_RESET;
            ctrl_b     <= CTRL_B_RESET;
            flags      <= FLAGS_RESET;
            irq_active <= 1'b0;
        end else begin
            ctrl_a     <= next_ctrl_a;
            ctrl_b     <= next_ctrl_b;
            flags      <= next_flags;
            irq_active <= next_irq_active;
        end
    end

    // open drain: pull low or float
    assign o_irq_n     = 1'b0;
    assign o_irq_n_oe  = irq_active;
    assign o_control_a = ctrl_a;
    assign o_control_b = ctrl_b;

    // ****************************************************************
    // clock bytes and general-purpose RAM
    // ****************************************************************
    logic [7:0] mem [MEM_WORDS];
    logic       mem_addr;

    assign mem_addr = (addr < REG_CTRL_A) || (addr >= RAM_FIRST);

    // reset pin never touches this array
    always_ff @(posedge i_clk) begin
        if (i_power_fail && !clr_n_s) begin
            for (int i = int'(RAM_FIRST); i < MEM_WORDS; i++) begin
                mem[i] <= RAM_FILL;
            end
        end else if (write_take && mem_addr) begin
            mem[addr] <= ad_p;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [7:0] rd_data;
    logic [7:0] next_rd_data;

    // read mux, registered ahead of the drive window
    always_comb begin
        next_rd_data = 8'h00;
        unique case (addr)
            REG_CTRL_A: next_rd_data = {i_update_in_progress, ctrl_a};
            REG_CTRL_B: next_rd_data = ctrl_b;
            REG_STATUS: next_rd_data = {irq_active, flags, 4'h0};
            REG_VALID:  next_rd_data = {i_supply_valid, 7'h00};
            default:    next_rd_data = mem[addr];
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    assign o_shared_addr_data = rd_data;

    // ****************************************************************
    // oscillator tick and divider chain
    // ****************************************************************
    localparam logic [10:0] TICK_LAST = 11'(OSC_TICK_CYCLES - 1);

    logic [10:0]           tick_cnt;
    logic [DIV_STAGES-1:0] chain;
    logic                  sq_out;
    logic [10:0]           next_tick_cnt;
    logic [DIV_STAGES-1:0] next_chain;
    logic                  next_sq_out;
    logic                  tap;

    // tap chosen by the rate field, rate zero gives none
    always_comb begin
        unique case (ctrl_a[3:0])
            4'h0:    tap = 1'b0;
            4'h1:    tap = chain[6];
            4'h2:    tap = chain[7];
            default: tap = chain[ctrl_a[3:0] - 4'h2];
        endcase
    end

    always_comb begin
        next_tick_cnt = tick_cnt + 11'h001;
        next_chain    = chain;
        if (tick_cnt == TICK_LAST) begin
            next_tick_cnt = 11'h000;
            next_chain    = chain + 15'h0001;
        end
        // gated by enable and supply
        next_sq_out = tap & ctrl_b[B_SQUARE_WAVE_ENABLE_BIT] & ~i_power_fail;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tick_cnt <= 11'h000;
            chain    <= 15'h0000;
            sq_out   <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            chain    <= next_chain;
            sq_out   <= next_sq_out;
        end
    end

    assign o_square_wave_out = sq_out;

endmodule

// ===== testbench/rtc_host_monitor.sv
// assertion checker for the muxed-bus clock host port
`timescale 1ns/1ps

module rtc_host_monitor (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       i_chip_select_n,
    input wire logic       i_reset_n,
    input wire logic       i_power_fail,
    input wire logic       i_periodic_event,
    input wire logic       i_update_event,
    input wire logic       o_shared_addr_data_oe,
    input wire logic       o_irq_n_oe,
    input wire logic       o_square_wave_out,
    input wire logic [6:0] o_control_a,
    input wire logic [7:0] o_control_b
);
    // one clock domain, system reset disables all
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // reset pin held low while supply is good
    sequence s_pin_reset;
        (!i_reset_n && !i_power_fail) [*5];
    endsequence

    // no selection and no reset pin for a while
    sequence s_idle;
        (i_chip_select_n && i_reset_n) [*5];
    endsequence

    // port relations
    a_pin_reset_clears: assert property (s_pin_reset |-> o_control_b[6:3] == 4'h0 && !o_irq_n_oe)
        else $error("reset pin left enables or irq set");
    a_idle_regs_hold: assert property (s_idle |=> $stable(o_control_a) && $stable(o_control_b))
        else $error("control changed without access");
    a_deselect_no_drive: assert property (i_chip_select_n [*5] |-> !o_shared_addr_data_oe)
        else $error("bus driven while deselected");
    a_fail_no_drive: assert property (i_power_fail [*3] |-> !o_shared_addr_data_oe)
        else $error("bus driven during power fail");
    a_sqw_needs_enable: assert property ((!o_control_b[3]) [*2] |-> !o_square_wave_out)
        else $error("square wave without enable");
    a_sqw_fail_quiet: assert property (i_power_fail [*2] |-> !o_square_wave_out)
        else $error("square wave during power fail");
    a_periodic_irq: assert property (i_periodic_event && o_control_b[6] && i_reset_n |-> ##[1:2] o_irq_n_oe)
        else $error("periodic event raised no irq");
    a_update_irq: assert property (i_update_event && o_control_b[4] && i_reset_n |-> ##[1:2] o_irq_n_oe)
        else $error("update event raised no irq");
    a_irq_needs_enable: assert property ((o_control_b[6:4] == 3'h0) [*3] |-> !o_irq_n_oe)
        else $error("irq without any enable");
endmodule

bind muxed_bus_rtc_host_port rtc_host_monitor i_monitor (
    .i_clk, .i_reset, .i_chip_select_n, .i_reset_n, .i_power_fail, .i_periodic_event, .i_update_event,
    .o_shared_addr_data_oe, .o_irq_n_oe, .o_square_wave_out, .o_control_a, .o_control_b
);

// ===== testbench/cpu_bus_model.sv
// processor-side model driving the muxed address/data bus
`timescale 1ns/1ps

module cpu_bus_model (
    input  wire logic       i_clk,
    input  wire logic       i_mode,
    output logic            o_addr_strobe,
    output logic            o_data_strobe,
    output logic            o_read_write,
    output logic            o_chip_select_n,
    output logic      [7:0] o_bus,
    output logic            o_bus_oe
);
    // idle bus at time zero
    initial begin
        o_addr_strobe = 1'b0;
        o_data_strobe = 1'b0;
        o_read_write = 1'b1;
        o_chip_select_n = 1'b1;
        o_bus = 8'h00;
        o_bus_oe = 1'b0;
    end

    // one whole bus cycle, each level held at least 4 clocks for the synchronisers
    task automatic xfer(input logic rd, input logic [7:0] adr, input logic [7:0] wdat, input logic sel);
        @(posedge i_clk);
        o_bus_oe        <= 1'b1;
        o_bus           <= adr;
        o_addr_strobe   <= 1'b1;                // fresh address before every access
        o_chip_select_n <= ~sel;                // held through all strobes
        o_data_strobe   <= ~i_mode;
        o_read_write    <= i_mode ? rd : 1'b1;  // direction level
        repeat (4) @(posedge i_clk);
        o_addr_strobe   <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_bus_oe        <= ~rd;
        o_bus           <= wdat;
        if (i_mode) o_data_strobe <= 1'b1;
        else if (rd) o_data_strobe <= 1'b0;     // read enable
        else o_read_write <= 1'b0;              // write enable
        repeat (6) @(posedge i_clk);
        o_data_strobe   <= ~i_mode;
        repeat (4) @(posedge i_clk);
        o_read_write    <= 1'b1;                // direction held past strobe fall
        repeat (4) @(posedge i_clk);
        o_chip_select_n <= 1'b1;
        o_bus_oe        <= 1'b0;
    endtask
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the muxed-bus clock host port
`timescale 1ns/1ps

module testbench;
    // device reset pin held low with the power-up reset, scaled down in time
    logic       i_clk = 1'b0, i_reset = 1'b1, i_bus_type_select = 1'b1, i_reset_n = 1'b0;
    logic       i_ram_clear_n = 1'b1, i_power_fail = 1'b0, i_supply_valid = 1'b1, i_update_in_progress = 1'b1;
    logic       i_periodic_event = 1'b0, i_alarm_event = 1'b0, i_update_event = 1'b0;
    wire  [7:0] i_shared_addr_data, o_shared_addr_data, cpu_data;
    wire        o_shared_addr_data_oe, cpu_oe, i_addr_strobe, i_data_strobe, i_read_write, i_chip_select_n;
    wire        o_irq_n, o_irq_n_oe, o_square_wave_out;
    wire  [6:0] o_control_a;
    wire  [7:0] o_control_b;
    logic [7:0] expect_q[$];
    logic [7:0] seen, a, d;
    logic       was_oe = 1'b0;
    int         miscompares = 0, checks_done = 0, seed = 57, k;

    always #10 i_clk = ~i_clk;

    // released bus shows the inverse of the model's current cpu_data byte
    assign i_shared_addr_data = o_shared_addr_data_oe ? o_shared_addr_data : cpu_oe ? cpu_data : ~cpu_data;

    muxed_bus_rtc_host_port i_dut (
        .i_clk, .i_reset, .i_bus_type_select, .i_shared_addr_data, .o_shared_addr_data, .o_shared_addr_data_oe,
        .i_addr_strobe, .i_data_strobe, .i_read_write, .i_chip_select_n, .i_reset_n, .i_ram_clear_n,
        .i_power_fail, .i_supply_valid, .i_update_in_progress, .i_periodic_event, .i_alarm_event,
        .i_update_event, .o_irq_n, .o_irq_n_oe, .o_square_wave_out, .o_control_a, .o_control_b
    );

    cpu_bus_model i_cpu (
        .i_clk, .i_mode(i_bus_type_select), .o_addr_strobe(i_addr_strobe), .o_data_strobe(i_data_strobe),
        .o_read_write(i_read_write), .o_chip_select_n(i_chip_select_n), .o_bus(cpu_data), .o_bus_oe(cpu_oe)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] want);
        checks_done++;
        if (got !== want) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h", $time, got, want);
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] val);
        i_cpu.xfer(1'b0, adr, val, 1'b1);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [7:0] want);
        expect_q.push_back(want);
        i_cpu.xfer(1'b1, adr, 8'h00, 1'b1);
    endtask

    task automatic summarize;
        if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // read bytes come off the queue as the device lets go of the bus
    always @(posedge i_clk) begin
        if (o_shared_addr_data_oe === 1'b1) seen <= o_shared_addr_data;
        else if (was_oe === 1'b1) check(seen, expect_q.size() > 0 ? expect_q.pop_front() : ~seen);
        was_oe <= o_shared_addr_data_oe;
    end

    // main sequence
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        i_reset_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        for (k = 0; k < 8; k++) begin
            i_bus_type_select <= k[0];
            repeat (4) @(posedge i_clk);
            a = 8'h0E + 8'($random(seed) & 63);
            d = 8'($random(seed));
            wr(a, d);
            rd(a, d);
        end
        // deselected and power-failed cycles leave the byte alone
        i_cpu.xfer(1'b0, a, ~d, 1'b0);
        i_cpu.xfer(1'b1, a, 8'h00, 1'b0);
        i_power_fail <= 1'b1;
        wr(a, ~d);
        i_cpu.xfer(1'b1, a, 8'h00, 1'b1);
        i_power_fail <= 1'b0;
        rd(a, d);
        wr(8'h0D, 8'h7F);
        wr(8'h0C, 8'hFF);
        rd(8'h0D, 8'h80);
        rd(8'h0C, 8'h00);
        wr(8'h0A, 8'h03);
        rd(8'h0A, 8'h83);
        check(8'(o_control_a), 8'h03);
        // masked alarm stays quiet, enabled periodic pulls irq
        wr(8'h0B, 8'h48);
        i_alarm_event <= 1'b1;
        @(posedge i_clk);
        i_alarm_event <= 1'b0;
        repeat (3) @(posedge i_clk);
        check(8'(o_irq_n_oe), 8'h00);
        i_periodic_event <= 1'b1;
        @(posedge i_clk);
        i_periodic_event <= 1'b0;
        repeat (3) @(posedge i_clk);
        check(8'(o_irq_n_oe), 8'h01);
        check(8'(o_irq_n), 8'h00);
        rd(8'h0C, 8'hE0);
        repeat (3) @(posedge i_clk);
        check(8'(o_irq_n_oe), 8'h00);
        // square wave runs with enable, stops on power fail
        for (k = 0; k < 8000 && o_square_wave_out !== 1'b1; k++) @(posedge i_clk);
        check(8'(o_square_wave_out), 8'h01);
        i_power_fail <= 1'b1;
        repeat (3) @(posedge i_clk);
        check(8'(o_square_wave_out), 8'h00);
        i_power_fail <= 1'b0;
        // reset pin clears enables and irq, keeps data
        wr(8'h0B, 8'h78);
        i_update_event <= 1'b1;
        @(posedge i_clk);
        i_update_event <= 1'b0;
        repeat (3) @(posedge i_clk);
        check(8'(o_irq_n_oe), 8'h01);
        i_reset_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        check(o_control_b, 8'h00);
        check(8'(o_irq_n_oe), 8'h00);
        wr(a, ~d);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(a, d);
        rd(8'h0C, 8'h10);
        // ram clear in backup fills general bytes only
        wr(8'h00, 8'h5A);
        i_power_fail <= 1'b1;
        i_ram_clear_n <= 1'b0;
        repeat (300) @(posedge i_clk);
        i_ram_clear_n <= 1'b1;
        i_power_fail <= 1'b0;
        repeat (4) @(posedge i_clk);
        rd(a, 8'hFF);
        rd(8'h7F, 8'hFF);
        rd(8'h00, 8'h5A);
        repeat (10) @(posedge i_clk);
        check(8'(expect_q.size()), 8'h00);
        summarize();
    end

    // cut a hang short
    initial begin
        repeat (40000) @(posedge i_clk);
        miscompares++;
        summarize();
    end
endmodule
